// ==== design/bmu_pkg.sv ====
// Shared constants, operation codes and decode functions of the bit-manipulation unit.
package bmu_pkg;

  // ----------------------------------------------------------------
  // Widths
  // ----------------------------------------------------------------
  localparam int BMU_DATA_W = 8;
  localparam int BMU_BIT_W  = 3;
  localparam int BMU_ADDR_W = 16;

  // ----------------------------------------------------------------
  // Reset values and the single-bit mask constant
  // ----------------------------------------------------------------
  localparam logic [BMU_DATA_W-1:0] BMU_BYTE_RST = 8'h00;
  localparam logic [BMU_ADDR_W-1:0] BMU_ADDR_RST = 16'h0000;
  localparam logic [BMU_BIT_W-1:0]  BMU_BIT_RST  = 3'h0;
  localparam logic [BMU_DATA_W-1:0] BMU_BIT_ONE  = 8'h01;

  // ----------------------------------------------------------------
  // Operation codes
  // ----------------------------------------------------------------
  typedef enum logic [3:0] {
    BMU_SET_BIT_OP             = 4'h0,
    BMU_CLEAR_BIT_OP           = 4'h1,
    BMU_INVERT_BIT_OP          = 4'h2,
    BMU_TEST_BIT_OP            = 4'h3,
    BMU_AND_CARRY_OP           = 4'h4,
    BMU_AND_CARRY_INVERTED_OP  = 4'h5,
    BMU_OR_CARRY_OP            = 4'h6,
    BMU_OR_CARRY_INVERTED_OP   = 4'h7,
    BMU_XOR_CARRY_OP           = 4'h8,
    BMU_XOR_CARRY_INVERTED_OP  = 4'h9,
    BMU_LOAD_CARRY_OP          = 4'hA,
    BMU_LOAD_CARRY_INVERTED_OP = 4'hB,
    BMU_STORE_CARRY_OP         = 4'hC,
    BMU_STORE_CARRY_INVERTED_OP = 4'hD
  } bmu_op_t;

  // ----------------------------------------------------------------
  // Decode functions
  // ----------------------------------------------------------------
  function automatic logic bmu_modifies(input bmu_op_t op);
    return (op == BMU_SET_BIT_OP) || (op == BMU_CLEAR_BIT_OP) ||
           (op == BMU_INVERT_BIT_OP) || (op == BMU_STORE_CARRY_OP) ||
           (op == BMU_STORE_CARRY_INVERTED_OP);
  endfunction

  function automatic logic bmu_writes_carry(input bmu_op_t op);
    return (op >= BMU_AND_CARRY_OP) && (op <= BMU_LOAD_CARRY_INVERTED_OP);
  endfunction

  function automatic logic bmu_inverted(input bmu_op_t op);
    return (op == BMU_AND_CARRY_INVERTED_OP) || (op == BMU_OR_CARRY_INVERTED_OP) ||
           (op == BMU_XOR_CARRY_INVERTED_OP) || (op == BMU_LOAD_CARRY_INVERTED_OP) ||
           (op == BMU_STORE_CARRY_INVERTED_OP);
  endfunction

  function automatic logic bmu_known(input bmu_op_t op);
    return op <= BMU_STORE_CARRY_INVERTED_OP;
  endfunction

endpackage

// ==== design/bmu_bit_alu.sv ====
// Registered bit operator: modifies one bit of a byte or derives a flag from it.
`timescale 1ns/1ps
`default_nettype none
module bmu_bit_alu (
  // Clock and reset
  input  wire logic                           clk,
  input  wire logic                           rst_n,
  // Operands
  input  wire logic                           load,
  input  wire bmu_pkg::bmu_op_t               op,
  input  wire logic [bmu_pkg::BMU_BIT_W-1:0]  bit_no,
  input  wire logic [bmu_pkg::BMU_DATA_W-1:0] operand,
  input  wire logic                           carry_in,
  // Results
  output logic      [bmu_pkg::BMU_DATA_W-1:0] result,
  output logic                                flag
);
  import bmu_pkg::*;

  logic [BMU_DATA_W-1:0] mask;
  logic                  sel;
  logic [BMU_DATA_W-1:0] kept;
  logic [BMU_DATA_W-1:0] next_result;
  logic                  next_flag;

  assign mask = BMU_BIT_ONE << bit_no;
  assign sel  = operand[bit_no];
  assign kept = operand & ~mask;

  // Flag-only operations return the byte untouched so a stray write-back is harmless.
  always_comb begin
    next_result = operand;
    next_flag   = carry_in;
    case (op)
      BMU_SET_BIT_OP:              next_result = operand | mask;                   // RULE1
      BMU_CLEAR_BIT_OP:            next_result = kept;                             // RULE2
      BMU_INVERT_BIT_OP:           next_result = operand ^ mask;                   // RULE3
      BMU_TEST_BIT_OP:             next_flag   = ~sel;                             // RULE4
      BMU_AND_CARRY_OP:            next_flag   = carry_in & sel;                   // RULE7
      BMU_AND_CARRY_INVERTED_OP:   next_flag   = carry_in & ~sel;                  // RULE8
      BMU_OR_CARRY_OP:             next_flag   = carry_in | sel;                   // RULE9
      BMU_OR_CARRY_INVERTED_OP:    next_flag   = carry_in | ~sel;                  // RULE10
      BMU_XOR_CARRY_OP:            next_flag   = carry_in ^ sel;                   // RULE11
      BMU_XOR_CARRY_INVERTED_OP:   next_flag   = carry_in ^ ~sel;                  // RULE12
      BMU_LOAD_CARRY_OP:           next_flag   = sel;                              // RULE13
      BMU_LOAD_CARRY_INVERTED_OP:  next_flag   = ~sel;                             // RULE14
      BMU_STORE_CARRY_OP:          next_result = kept | (carry_in ? mask : '0);    // RULE15
      BMU_STORE_CARRY_INVERTED_OP: next_result = kept | (carry_in ? '0 : mask);    // RULE16
      default:                     next_result = operand;
    endcase
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      result <= BMU_BYTE_RST;
      flag   <= 1'b0;
    end else if (load) begin
      result <= next_result;
      flag   <= next_flag;
    end
  end

endmodule
`default_nettype wire

// ==== design/bmu_core.sv ====
// Bit-manipulation unit: sequencer for register and memory operands, with checks.
//
// Summary of operation
// RULE1 - Set operation forces selected bit to one.
// RULE2 - Clear operation forces selected bit to zero.
// RULE3 - Invert operation complements the selected bit.
// RULE4 - Test loads zero flag with inverted bit.
// RULE5 - Bit number from immediate or register.
// RULE6 - Inverted operations take immediate bit number only.
// RULE7 - Carry becomes carry AND selected bit.
// RULE8 - Carry becomes carry AND inverted bit.
// RULE9 - Carry becomes carry OR selected bit.
// RULE10 - Carry becomes carry OR inverted bit.
// RULE11 - Carry becomes carry XOR selected bit.
// RULE12 - Carry becomes carry XOR inverted bit.
// RULE13 - Carry takes the selected bit.
// RULE14 - Carry takes the inverted selected bit.
// RULE15 - Selected bit takes the carry.
// RULE16 - Selected bit takes inverted carry.
// RULE17 - Memory operand is read, modified, written back.
// RULE18 - Flag operations leave operand byte untouched.
`timescale 1ns/1ps
`default_nettype none
module bmu_core #(
  parameter int DATA_W = bmu_pkg::BMU_DATA_W,
  parameter int ADDR_W = bmu_pkg::BMU_ADDR_W
) (
  // Clock and reset
  input  wire logic                           clk,
  input  wire logic                           rst_n,
  // Instruction request
  input  wire logic                           start,
  input  wire bmu_pkg::bmu_op_t               op,
  input  wire logic                           bit_from_reg,
  input  wire logic [bmu_pkg::BMU_BIT_W-1:0]  bit_imm,
  input  wire logic [bmu_pkg::BMU_DATA_W-1:0] bit_reg,
  input  wire logic                           target_mem,
  input  wire logic [bmu_pkg::BMU_DATA_W-1:0] reg_rdata,
  input  wire logic [bmu_pkg::BMU_ADDR_W-1:0] mem_addr_in,
  input  wire logic                           carry_in,
  // Instruction status
  output logic                                busy,
  output logic                                done,
  output logic                                refused,
  // Register and flag write-back
  output logic                                reg_we,
  output logic      [bmu_pkg::BMU_DATA_W-1:0] reg_wdata,
  output logic                                carry_we,
  output logic                                carry_out,
  output logic                                zero_we,
  output logic                                zero_out,
  // Memory access
  output logic                                mem_req,
  output logic                                mem_we,
  output logic      [bmu_pkg::BMU_ADDR_W-1:0] mem_addr,
  output logic      [bmu_pkg::BMU_DATA_W-1:0] mem_wdata,
  input  wire logic                           mem_ack,
  input  wire logic [bmu_pkg::BMU_DATA_W-1:0] mem_rdata
);
  import bmu_pkg::*;

  // ----------------------------------------------------------------
  // Elaboration checks
  // ----------------------------------------------------------------
  // The datapath is byte-wide with a 3-bit bit number; other widths are not served.
  if (DATA_W != BMU_DATA_W) begin : g_bad_data_w
    $error("bmu_core: DATA_W must equal 8");
  end
  if (ADDR_W != BMU_ADDR_W) begin : g_bad_addr_w
    $error("bmu_core: ADDR_W must match the package address width");
  end
  // Every bit of the byte must be reachable by the bit number and no code may point past it.
  if (BMU_DATA_W != (1 << BMU_BIT_W)) begin : g_bad_bit_w
    $error("bmu_core: bit number width does not match the byte");
  end

  // ----------------------------------------------------------------
  // Sequencer states
  // ----------------------------------------------------------------
  typedef enum logic [4:0] {
    BMU_ST_IDLE  = 5'b00001,
    BMU_ST_READ  = 5'b00010,
    BMU_ST_EXEC  = 5'b00100,
    BMU_ST_WRITE = 5'b01000,
    BMU_ST_DONE  = 5'b10000
  } bmu_state_t;

  bmu_state_t            state;
  bmu_state_t            next_state;
  bmu_op_t               op_q;
  logic [BMU_BIT_W-1:0]  bit_q;
  logic [BMU_DATA_W-1:0] operand_q;
  logic                  carry_q;
  logic                  mem_tgt_q;
  logic [BMU_DATA_W-1:0] result;
  logic                  flag;

  // ----------------------------------------------------------------
  // Request decode
  // ----------------------------------------------------------------
  logic                 st_idle;
  logic                 st_read;
  logic                 st_exec;
  logic                 st_write;
  logic                 st_done;
  logic                 bad_request;
  logic                 accept;
  logic [BMU_BIT_W-1:0] bit_sel;
  logic                 op_modifies;

  assign st_idle  = (state == BMU_ST_IDLE);
  assign st_read  = (state == BMU_ST_READ);
  assign st_exec  = (state == BMU_ST_EXEC);
  assign st_write = (state == BMU_ST_WRITE);
  assign st_done  = (state == BMU_ST_DONE);

  // A register-held bit number is refused for the inverted forms; an unknown code too.
  assign bad_request = (bit_from_reg && bmu_inverted(op)) || !bmu_known(op);        // RULE6
  assign accept      = start && st_idle && !bad_request;
  assign refused     = start && st_idle && bad_request;
  assign bit_sel     = bit_from_reg ? bit_reg[BMU_BIT_W-1:0] : bit_imm;              // RULE5
  assign op_modifies = bmu_modifies(op_q);

  // ----------------------------------------------------------------
  // Next-state logic
  // ----------------------------------------------------------------
  always_comb begin
    next_state = state;
    case (state)
      BMU_ST_IDLE: begin
        if (accept) begin
          next_state = target_mem ? BMU_ST_READ : BMU_ST_EXEC;
        end
      end
      BMU_ST_READ: begin
        if (mem_ack) begin
          next_state = BMU_ST_EXEC;
        end
      end
      BMU_ST_EXEC: begin
        // Only bit-modifying operations write the memory byte back.
        next_state = (mem_tgt_q && op_modifies) ? BMU_ST_WRITE : BMU_ST_DONE;          // RULE18
      end
      BMU_ST_WRITE: begin
        if (mem_ack) begin
          next_state = BMU_ST_DONE;
        end
      end
      BMU_ST_DONE: next_state = BMU_ST_IDLE;
      default:     next_state = BMU_ST_IDLE;
    endcase
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      state <= BMU_ST_IDLE;
    end else begin
      state <= next_state;
    end
  end

  // ----------------------------------------------------------------
  // Operand capture
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      op_q      <= BMU_SET_BIT_OP;
      bit_q     <= BMU_BIT_RST;
      carry_q   <= 1'b0;
      mem_tgt_q <= 1'b0;
      mem_addr  <= BMU_ADDR_RST;
    end else if (accept) begin
      op_q      <= op;
      bit_q     <= bit_sel;
      carry_q   <= carry_in;
      mem_tgt_q <= target_mem;
      mem_addr  <= mem_addr_in;
    end
  end

  // The whole memory byte is fetched so the untouched bits go back unchanged.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      operand_q <= BMU_BYTE_RST;
    end else if (accept && !target_mem) begin
      operand_q <= reg_rdata;
    end else if (st_read && mem_ack) begin
      operand_q <= mem_rdata;                                                        // RULE17
    end
  end

  // ----------------------------------------------------------------
  // Datapath
  // ----------------------------------------------------------------
  bmu_bit_alu bmu_bit_alu_i (
    .clk      (clk),
    .rst_n    (rst_n),
    .load     (st_exec),
    .op       (op_q),
    .bit_no   (bit_q),
    .operand  (operand_q),
    .carry_in (carry_q),
    .result   (result),
    .flag     (flag)
  );

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign busy      = !st_idle;
  assign done      = st_done;
  assign reg_we    = st_done && !mem_tgt_q && op_modifies;                           // RULE18
  assign reg_wdata = result;
  assign carry_we  = st_done && bmu_writes_carry(op_q);
  assign carry_out = flag;
  assign zero_we   = st_done && (op_q == BMU_TEST_BIT_OP);                           // RULE4
  assign zero_out  = flag;
  assign mem_req   = st_read || st_write;
  assign mem_we    = st_write;                                                       // RULE17
  assign mem_wdata = result;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  logic [BMU_DATA_W-1:0] mask_q;
  logic                  sel_q;
  assign mask_q = BMU_BIT_ONE << bit_q;
  assign sel_q  = operand_q[bit_q];

  a_set_result: assert property (st_done && op_q == BMU_SET_BIT_OP |->    // RULE1
    result == (operand_q | mask_q)) else $error("set result wrong");
  a_clear_result: assert property (st_done && op_q == BMU_CLEAR_BIT_OP |->    // RULE2
    result == (operand_q & ~mask_q)) else $error("clear result wrong");
  a_invert_result: assert property (st_done && op_q == BMU_INVERT_BIT_OP |->    // RULE3
    result == (operand_q ^ mask_q)) else $error("invert result wrong");
  a_test_zero: assert property (zero_we |-> zero_out == !sel_q)    // RULE4
    else $error("test zero flag wrong");
  a_bit_source: assert property (accept |=> bit_q == $past(bit_sel))    // RULE5
    else $error("bit number not captured");
  a_refuse_reg_src: assert property (refused |=> st_idle && !mem_req)    // RULE6
    else $error("inverted op with register bit not refused");
  a_and_carry: assert property (carry_we && op_q == BMU_AND_CARRY_OP |->    // RULE7
    carry_out == (carry_q & sel_q)) else $error("and carry wrong");
  a_and_inv_carry: assert property (carry_we && op_q == BMU_AND_CARRY_INVERTED_OP |->    // RULE8
    carry_out == (carry_q & !sel_q)) else $error("inverted and carry wrong");
  a_or_carry: assert property (carry_we && op_q == BMU_OR_CARRY_OP |->    // RULE9
    carry_out == (carry_q | sel_q)) else $error("or carry wrong");
  a_or_inv_carry: assert property (carry_we && op_q == BMU_OR_CARRY_INVERTED_OP |->    // RULE10
    carry_out == (carry_q | !sel_q)) else $error("inverted or carry wrong");
  a_xor_carry: assert property (carry_we && op_q == BMU_XOR_CARRY_OP |->    // RULE11
    carry_out == (carry_q ^ sel_q)) else $error("xor carry wrong");
  a_xor_inv_carry: assert property (carry_we && op_q == BMU_XOR_CARRY_INVERTED_OP |->    // RULE12
    carry_out == (carry_q ^ !sel_q)) else $error("inverted xor carry wrong");
  a_load_carry: assert property (carry_we && op_q == BMU_LOAD_CARRY_OP |->    // RULE13
    carry_out == sel_q) else $error("load carry wrong");
  a_load_inv_carry: assert property (carry_we && op_q == BMU_LOAD_CARRY_INVERTED_OP |->    // RULE14
    carry_out == !sel_q) else $error("inverted load carry wrong");
  a_store_bit: assert property (st_done && op_q == BMU_STORE_CARRY_OP |->    // RULE15
    result == ((operand_q & ~mask_q) | (carry_q ? mask_q : '0))) else $error("store wrong");
  a_store_inv_bit: assert property (st_done && op_q == BMU_STORE_CARRY_INVERTED_OP |->    // RULE16
    result == ((operand_q & ~mask_q) | (carry_q ? '0 : mask_q))) else $error("inv store wrong");
  a_mem_rmw: assert property (st_write |-> (mem_wdata & ~mask_q) == (operand_q & ~mask_q))    // RULE17
    else $error("memory write changed other bits");
  a_mem_path: assert property (accept && target_mem |=> st_read && mem_req && !mem_we)    // RULE17
    else $error("memory operand not read first");
  a_flag_only: assert property (st_exec && !op_modifies |=> st_done && !reg_we && !mem_req)    // RULE18
    else $error("flag operation touched operand");
  a_reg_timing: assert property (accept && !target_mem |-> ##2 done)
    else $error("register operation not done in two cycles");

  // A slow memory must see one steady access, so the request holds until its acknowledge.
  a_mem_hold: assert property (mem_req && !mem_ack |=>    // RULE17
    mem_req && $stable(mem_we) && $stable(mem_addr) && $stable(mem_wdata))
    else $error("memory access changed before acknowledge");
  a_read_capture: assert property (st_read && mem_ack |=>    // RULE17
    operand_q == $past(mem_rdata)) else $error("memory byte not captured");
  a_write_done: assert property (st_write && mem_ack |=> done)    // RULE17
    else $error("write acknowledge did not finish the operation");
  a_write_only_modify: assert property (mem_we |-> op_modifies && mem_tgt_q)    // RULE18
    else $error("memory written by a flag operation");
  a_carry_sample: assert property (accept |=> carry_q == $past(carry_in))    // RULE7
    else $error("carry not sampled at the request");
  // Data outputs hold between operations so a late reader still sees the last result.
  a_result_hold: assert property (!st_exec |=> $stable(result))    // RULE18
    else $error("result changed outside execution");
  a_done_pulse: assert property (done |=> !done && st_idle)
    else $error("done did not return to idle");
  a_reg_capture: assert property (accept && !target_mem |=> operand_q == $past(reg_rdata))
    else $error("register operand not captured");

  c_reg_modify: cover property (reg_we && op_q == BMU_INVERT_BIT_OP);
  c_mem_modify: cover property (st_write && mem_ack ##1 done);
  c_mem_test: cover property (zero_we && mem_tgt_q);
  c_refused: cover property (refused);
  c_reg_carry: cover property (carry_we && !mem_tgt_q);

endmodule
`default_nettype wire

// ==== tb/bmu_core_tb_top.sv ====
// Self-checking testbench of the bit-manipulation unit with a behavioural memory responder.
`timescale 1ns/1ps
`default_nettype none
module bmu_core_tb_top;
  import bmu_pkg::*;

  // ----------------------------------------------------------------
  // Stimulus and observed signals
  // ----------------------------------------------------------------
  logic        clk, rst_n, start, bit_from_reg, target_mem, carry_in, mem_ack;
  bmu_op_t     op;
  logic [2:0]  bit_imm;
  logic [7:0]  bit_reg, reg_rdata, mem_rdata, reg_wdata, mem_wdata, mem_byte;
  logic [15:0] mem_addr_in, mem_addr, seen_addr;
  logic        busy, done, refused, reg_we, carry_we, carry_out, zero_we, zero_out;
  logic        mem_req, mem_we;
  int          miscompares, n_tests, cycles, ack_wait, wait_cnt, n_writes, n_reads;

  bmu_core bmu_core_i (
    .clk(clk), .rst_n(rst_n), .start(start), .op(op), .bit_from_reg(bit_from_reg),
    .bit_imm(bit_imm), .bit_reg(bit_reg), .target_mem(target_mem), .reg_rdata(reg_rdata),
    .mem_addr_in(mem_addr_in), .carry_in(carry_in), .busy(busy), .done(done),
    .refused(refused), .reg_we(reg_we), .reg_wdata(reg_wdata), .carry_we(carry_we),
    .carry_out(carry_out), .zero_we(zero_we), .zero_out(zero_out), .mem_req(mem_req),
    .mem_we(mem_we), .mem_addr(mem_addr), .mem_wdata(mem_wdata), .mem_ack(mem_ack),
    .mem_rdata(mem_rdata)
  );

  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  // ----------------------------------------------------------------
  // Memory responder: one-cycle ack after a set wait, data toggles when not valid
  // ----------------------------------------------------------------
  always @(posedge clk) begin
    mem_ack   <= 1'b0;
    mem_rdata <= ~mem_rdata;
    if (mem_req && mem_ack) begin
      seen_addr = mem_addr;
      wait_cnt  = 0;
      if (mem_we) begin
        mem_byte = mem_wdata;
        n_writes++;
      end else begin
        n_reads++;
      end
    end else if (mem_req) begin
      if (wait_cnt >= ack_wait) begin
        mem_ack   <= 1'b1;
        mem_rdata <= mem_byte;
      end
      wait_cnt++;
    end
  end

  // ----------------------------------------------------------------
  // Checking, verdict and hang limit
  // ----------------------------------------------------------------
  task automatic check(input logic [15:0] seen, input logic [15:0] exp, input string what);
    n_tests++;
    if (seen !== exp) begin
      miscompares++;
      $display("MISMATCH t=%0t %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask

  task automatic print_verdict();
    $display("Comparisons %0d, mismatches %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  // The whole table takes well under 2000 cycles; the ceiling leaves ample margin.
  always @(posedge clk) begin
    cycles++;
    if (cycles == 6000) begin
      miscompares++;
      print_verdict();
    end
  end

  // ----------------------------------------------------------------
  // One instruction from request to completion, judged on its outputs
  // ----------------------------------------------------------------
  task automatic run_op(input logic [3:0] k, input logic mem, input logic from_reg,
                        input logic [2:0] b, input logic [7:0] d, input logic c,
                        input int wt);
    logic [7:0]  nd;
    logic [15:0] addr;
    logic        sel, nc, z, modf, cw, zw;
    int          n, wr0, rd0;
    sel  = d[b];
    nd   = d;
    nc   = c;
    z    = 1'b0;
    modf = (k <= 4'h2) || (k >= 4'hC);
    cw   = (k >= 4'h4) && (k <= 4'hB);
    zw   = (k == 4'h3);
    case (k)
      4'h0: nd[b] = 1'b1;
      4'h1: nd[b] = 1'b0;
      4'h2: nd[b] = ~sel;
      4'h3: z = ~sel;
      4'h4: nc = c & sel;
      4'h5: nc = c & ~sel;
      4'h6: nc = c | sel;
      4'h7: nc = c | ~sel;
      4'h8: nc = c ^ sel;
      4'h9: nc = c ^ ~sel;
      4'hA: nc = sel;
      4'hB: nc = ~sel;
      4'hC: nd[b] = c;
      default: nd[b] = ~c;
    endcase
    addr     = {d, ~d};
    mem_byte = d;
    ack_wait = wt;
    wr0      = n_writes;
    rd0      = n_reads;
    @(posedge clk);
    start        <= 1'b1;
    op           <= bmu_op_t'(k);
    target_mem   <= mem;
    bit_from_reg <= from_reg;
    bit_imm      <= from_reg ? ~b : b;
    bit_reg      <= from_reg ? {5'b1_0101, b} : {5'b1_1111, ~b};
    reg_rdata    <= mem ? ~d : d;
    mem_addr_in  <= addr;
    carry_in     <= c;
    @(posedge clk);
    start    <= 1'b0;
    carry_in <= ~c;
    n = 0;
    do begin
      @(negedge clk);
      n++;
    end while (done !== 1'b1 && n < 40);
    check(16'(done), 16'h0001, "done");
    check(16'(reg_we), 16'(modf && !mem), "reg_we");
    check(16'(carry_we), 16'(cw), "carry_we");
    check(16'(zero_we), 16'(zw), "zero_we");
    if (cw) check(16'(carry_out), 16'(nc), "carry");
    if (zw) check(16'(zero_out), 16'(z), "zero flag");
    if (modf && !mem) check(16'(reg_wdata), 16'(nd), "reg result");
    if (mem) begin
      check(16'(n_reads - rd0), 16'h0001, "mem reads");
      check(16'(n_writes - wr0), 16'(modf), "mem writes");
      check(16'(mem_byte), 16'(nd), "mem byte");
      check(seen_addr, addr, "mem address");
    end
    @(negedge clk);
    check(16'({busy, done, mem_req}), 16'h0000, "idle after done");
  endtask

  // ----------------------------------------------------------------
  // Start while busy: the second request must be ignored
  // ----------------------------------------------------------------
  task automatic busy_start();
    int n;
    mem_byte = 8'h0F;
    ack_wait = 3;
    @(posedge clk);
    start        <= 1'b1;
    op           <= BMU_CLEAR_BIT_OP;
    target_mem   <= 1'b1;
    bit_from_reg <= 1'b0;
    bit_imm      <= 3'h2;
    mem_addr_in  <= 16'h1234;
    @(posedge clk);
    op          <= BMU_SET_BIT_OP;
    bit_imm     <= 3'h7;
    mem_addr_in <= 16'h4321;
    @(posedge clk);
    start <= 1'b0;
    n = 0;
    do begin
      @(negedge clk);
      n++;
    end while (done !== 1'b1 && n < 40);
    check(16'(done), 16'h0001, "busy op done");
    check(16'(mem_byte), 16'h000B, "busy op byte");
    check(seen_addr, 16'h1234, "busy op address");
    repeat (3) begin
      @(negedge clk);
      check(16'({busy, done, mem_req}), 16'h0000, "start while busy");
    end
  endtask

  // ----------------------------------------------------------------
  // Reset in the middle of a register operation
  // ----------------------------------------------------------------
  task automatic reset_mid();
    @(posedge clk);
    start        <= 1'b1;
    op           <= BMU_SET_BIT_OP;
    target_mem   <= 1'b0;
    bit_from_reg <= 1'b0;
    bit_imm      <= 3'h0;
    reg_rdata    <= 8'h00;
    mem_addr_in  <= 16'h0F0F;
    @(posedge clk);
    start <= 1'b0;
    rst_n <= 1'b0;
    @(posedge clk);
    rst_n <= 1'b1;
    @(negedge clk);
    check(16'({busy, done, reg_we, carry_we, zero_we, mem_req}), 16'h0000, "mid reset");
    check(16'(reg_wdata), 16'h0000, "mid reset data");
    check(mem_addr, 16'h0000, "mid reset address");
    @(negedge clk);
    check(16'({busy, done, reg_we}), 16'h0000, "no op after reset");
  endtask

  // ----------------------------------------------------------------
  // Refused request: register bit source on an inverted op or unknown op
  // ----------------------------------------------------------------
  task automatic refuse_op(input logic [3:0] k);
    @(posedge clk);
    start        <= 1'b1;
    op           <= bmu_op_t'(k);
    bit_from_reg <= 1'b1;
    target_mem   <= 1'b0;
    @(negedge clk);
    check(16'(refused), 16'h0001, "refused");
    @(posedge clk);
    start <= 1'b0;
    repeat (4) begin
      @(negedge clk);
      check(16'({busy, done, reg_we, carry_we, mem_req}), 16'h0000, "no effect");
    end
  endtask

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    rst_n = 1'b0; start = 1'b0; op = BMU_SET_BIT_OP; bit_from_reg = 1'b0; bit_imm = 3'h0;
    bit_reg = 8'h00; target_mem = 1'b0; reg_rdata = 8'h00; mem_addr_in = 16'h0000;
    carry_in = 1'b0; mem_ack = 1'b0; mem_rdata = 8'h00; mem_byte = 8'h00;
    miscompares = 0; n_tests = 0; cycles = 0; ack_wait = 0; wait_cnt = 0;
    n_writes = 0; n_reads = 0; seen_addr = 16'h0000;
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    @(negedge clk);
    check(16'({busy, done, reg_we, mem_req, mem_we}), 16'h0000, "reset state");
    // Every op, register and memory targets, both bit sources except on the inverted ops, short and long ack waits.
    for (int k = 0; k < 14; k++) begin
      for (int v = 0; v < 4; v++) begin
        run_op(4'(k), v[1], v[0] && !(k > 4 && k % 2 == 1), 3'(k + v),
               8'h5A ^ 8'(k * 19 + v * 7), k[0] ^ v[0], v[0] ? 3 : 0);
      end
    end
    reset_mid();
    busy_start();
    for (int k = 5; k < 14; k += 2) begin
      refuse_op(4'(k));
    end
    refuse_op(4'hE);
    run_op(4'h2, 1'b0, 1'b1, 3'h7, 8'h80, 1'b0, 0);
    print_verdict();
  end
endmodule
`default_nettype wire
